// >>> core/rcr_consts.svh
// Register offsets, field positions and reset values of the reset cause recorder.
`ifndef RCR_CONSTS_SVH
`define RCR_CONSTS_SVH

// ****************************************************************
// Bus geometry
// ****************************************************************
`define RCR_ADDR_W 8
`define RCR_DATA_W 32
`define RCR_STRB_W 4

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define RCR_OFF_CTRL 8'h00
`define RCR_OFF_IRQ_STATUS 8'h04
`define RCR_OFF_IRQ_ENABLE 8'h08
`define RCR_OFF_IRQ_CLEAR 8'h0C

// ****************************************************************
// Field positions of the reset cause control register
// ****************************************************************
`define RCR_CTRL_W 10
`define RCR_BIT_CFG_MISMATCH 9
`define RCR_BIT_KEEP_ON 8
`define RCR_BIT_PIN_RESET 7
`define RCR_BIT_SOFT_RESET 6
`define RCR_BIT_WATCHDOG 4
`define RCR_BIT_WAKE_SLEEP 3
`define RCR_BIT_WAKE_IDLE 2
`define RCR_BIT_BROWNOUT 1
`define RCR_BIT_POWER_ON 0
`define RCR_EVT_W 8

// ****************************************************************
// Reset values, masks and bus answers
// ****************************************************************
`define RCR_CTRL_RESET 10'h003
`define RCR_CTRL_IMPL_MASK 10'h3DF
`define RCR_EVENT_MASK 10'h2DF
`define RCR_RESP_OKAY 2'b00
`define RCR_RESP_DECERR 2'b11

`endif

// >>> core/rcr_event_pulse.sv
// Turns event levels into one-cycle pulses on their rising edges.
`timescale 1ns/100ps
`default_nettype none

module rcr_event_pulse #(
  parameter int W = 8
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [W-1:0] level,
  output logic [W-1:0] pulse
);

  logic [W-1:0] prev_q;
  logic [W-1:0] pulse_q;
  logic [W-1:0] rise;

  // A level that stays high counts once, so a held source cannot pin a flag.
  assign rise = level & ~prev_q;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      prev_q <= '0;
      pulse_q <= '0;
    end else begin
      prev_q <= level;
      pulse_q <= rise;
    end
  end

  assign pulse = pulse_q;

endmodule // rcr_event_pulse

`default_nettype wire

// >>> core/rcr_flag_if.sv
// Interface between the register logic and a bank of sticky flags.
`timescale 1ns/100ps
`default_nettype none

interface rcr_flag_if #(
  parameter int W = 10
);
  logic [W-1:0] set;
  logic wr_en;
  logic [W-1:0] wr_data;
  logic [W-1:0] wr_mask;
  logic [W-1:0] q;

  modport bank (
    input set,
    input wr_en,
    input wr_data,
    input wr_mask,
    output q
  );

  modport ctrl (
    output set,
    output wr_en,
    output wr_data,
    output wr_mask,
    input q
  );
endinterface

`default_nettype wire

// >>> core/rcr_pkg.sv
// Types shared by the reset cause recorder modules.
package rcr_pkg;

  typedef enum logic [1:0] {
    RCR_WR_IDLE = 2'b01,
    RCR_WR_RESP = 2'b10
  } rcr_wr_state_e;

  typedef enum logic [1:0] {
    RCR_RD_IDLE = 2'b01,
    RCR_RD_RESP = 2'b10
  } rcr_rd_state_e;

endpackage

// >>> core/rcr_sticky_bank.sv
// Bank of sticky flags that hardware sets and software loads or clears.
`timescale 1ns/100ps
`default_nettype none

module rcr_sticky_bank #(
  parameter int W = 10,
  parameter logic [W-1:0] RESET_VAL = '0,
  parameter bit CLEAR_ON_ONE = 1'b0
) (
  input wire logic clk_sys,
  input wire logic rstn,
  rcr_flag_if.bank fl
);

  logic [W-1:0] q_q;
  logic [W-1:0] q_d;
  logic [W-1:0] lane;
  logic [W-1:0] written;

  assign lane = fl.wr_en ? fl.wr_mask : '0;
  assign written = CLEAR_ON_ONE ? (q_q & ~fl.wr_data) : fl.wr_data;
  // The set term is ORed over both write terms so that an event beats a clear in one cycle.
  assign q_d = fl.set | (lane & written) | (~lane & q_q);

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      q_q <= RESET_VAL;
    end else begin
      q_q <= q_d;
    end
  end

  assign fl.q = q_q;

endmodule // rcr_sticky_bank

`default_nettype wire

// >>> core/rcr_top.sv
// Reset cause recorder: sticky reset and wake flags behind an AXI4-Lite slave.
//
// Overview of operation
// - Set flag bit 9 on a configuration mismatch reset, otherwise leave clear.
// - Bit 8 is writable; one keeps the regulator on in sleep.
// - Set flag bit 7 on every reset from the master clear pin.
// - Set flag bit 6 whenever a software reset is executed.
// - Set flag bit 4 whenever the watchdog timer expires.
// - Set flag bit 3 on leaving sleep mode.
// - Set flag bit 2 on leaving idle mode.
// - Set flag bit 1 whenever a brown-out reset occurs.
// - Set flag bit 0 whenever a power-on reset occurs.
// - Bits 31 to 10 and bit 5 are unimplemented and read zero.
// - Flags are read/write by software, set by hardware, and sticky.
//
// Decided for this implementation: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "rcr_consts.svh"

module rcr_top (
  input wire logic clk_sys,
  input wire logic rstn,
  // AXI4-Lite write address channel.
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [`RCR_ADDR_W-1:0] s_axi_awaddr,
  // AXI4-Lite write data channel.
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [`RCR_DATA_W-1:0] s_axi_wdata,
  input wire logic [`RCR_STRB_W-1:0] s_axi_wstrb,
  // AXI4-Lite write response channel.
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read address channel.
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [`RCR_ADDR_W-1:0] s_axi_araddr,
  // AXI4-Lite read data channel.
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [`RCR_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Reset and power mode event sources, active high levels.
  input wire logic evt_config_mismatch,
  input wire logic evt_master_clear_pin,
  input wire logic evt_soft_reset,
  input wire logic evt_watchdog_expiry,
  input wire logic evt_wake_sleep,
  input wire logic evt_wake_idle,
  input wire logic evt_brownout,
  input wire logic evt_power_on,
  // Power control and interrupt outputs.
  output logic regulator_standby_keep_on,
  output logic irq
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  localparam int CW = `RCR_CTRL_W;
  localparam int PAD_W = `RCR_DATA_W - `RCR_CTRL_W;

  rcr_pkg::rcr_wr_state_e wr_state_q;
  rcr_pkg::rcr_wr_state_e wr_state_d;
  rcr_pkg::rcr_rd_state_e rd_state_q;
  rcr_pkg::rcr_rd_state_e rd_state_d;

  logic aw_got_q;
  logic w_got_q;
  logic [`RCR_ADDR_W-1:0] awaddr_q;
  logic [`RCR_DATA_W-1:0] wdata_q;
  logic [`RCR_STRB_W-1:0] wstrb_q;
  logic [1:0] bresp_q;
  logic [`RCR_DATA_W-1:0] rdata_q;
  logic [1:0] rresp_q;
  logic [CW-1:0] enable_q;
  logic [CW-1:0] enable_d;
  logic irq_q;

  logic aw_fire;
  logic w_fire;
  logic b_fire;
  logic ar_fire;
  logic r_fire;
  logic wr_commit;

  logic [`RCR_ADDR_W-1:0] wr_word;
  logic wr_sel_ctrl;
  logic wr_sel_status;
  logic wr_sel_enable;
  logic wr_sel_clear;
  logic wr_mapped;
  logic [CW-1:0] wr_lanes;
  logic [CW-1:0] wr_bits;

  logic [`RCR_ADDR_W-1:0] rd_word;
  logic rd_sel_ctrl;
  logic rd_sel_status;
  logic rd_sel_enable;
  logic rd_sel_clear;
  logic rd_mapped;
  logic [CW-1:0] rd_field;

  logic [`RCR_EVT_W-1:0] evt_level;
  logic [`RCR_EVT_W-1:0] evt_pulse;
  logic [CW-1:0] evt_bits;
  logic [CW-1:0] status;

  rcr_flag_if #(.W(CW)) ctrl_fl ();
  rcr_flag_if #(.W(CW)) stat_fl ();

  // ****************************************************************
  // Event capture
  // ****************************************************************
  assign evt_level = {evt_config_mismatch, evt_master_clear_pin,
                      evt_soft_reset, evt_watchdog_expiry, evt_wake_sleep,
                      evt_wake_idle, evt_brownout, evt_power_on};

  rcr_event_pulse #(
    .W(`RCR_EVT_W)
  ) u_event_pulse (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .level(evt_level),
    .pulse(evt_pulse)
  );

  // Each pulse lands on its own flag position; bits 8 and 5 have no event.
  always_comb begin
    evt_bits = '0;
    evt_bits[`RCR_BIT_CFG_MISMATCH] = evt_pulse[7];
    evt_bits[`RCR_BIT_PIN_RESET] = evt_pulse[6];
    evt_bits[`RCR_BIT_SOFT_RESET] = evt_pulse[5];
    evt_bits[`RCR_BIT_WATCHDOG] = evt_pulse[4];
    evt_bits[`RCR_BIT_WAKE_SLEEP] = evt_pulse[3];
    evt_bits[`RCR_BIT_WAKE_IDLE] = evt_pulse[2];
    evt_bits[`RCR_BIT_BROWNOUT] = evt_pulse[1];
    evt_bits[`RCR_BIT_POWER_ON] = evt_pulse[0];
  end

  // ****************************************************************
  // Write channel
  // ****************************************************************
  // Address and data are parked independently, so the master may offer
  // them in either order; the register update waits for both.
  assign s_axi_awready = (wr_state_q == rcr_pkg::RCR_WR_IDLE) && !aw_got_q;
  assign s_axi_wready = (wr_state_q == rcr_pkg::RCR_WR_IDLE) && !w_got_q;
  assign aw_fire = s_axi_awvalid && s_axi_awready;
  assign w_fire = s_axi_wvalid && s_axi_wready;
  assign b_fire = s_axi_bvalid && s_axi_bready;
  assign wr_commit = (wr_state_q == rcr_pkg::RCR_WR_IDLE) && aw_got_q &&
                     w_got_q;

  assign wr_word = {awaddr_q[`RCR_ADDR_W-1:2], 2'b00};
  assign wr_sel_ctrl = (wr_word == `RCR_OFF_CTRL);
  assign wr_sel_status = (wr_word == `RCR_OFF_IRQ_STATUS);
  assign wr_sel_enable = (wr_word == `RCR_OFF_IRQ_ENABLE);
  assign wr_sel_clear = (wr_word == `RCR_OFF_IRQ_CLEAR);
  assign wr_mapped = wr_sel_ctrl || wr_sel_status || wr_sel_enable ||
                     wr_sel_clear;

  // The ten live bits span byte lanes 0 and 1.
  assign wr_lanes = {{(CW - 8){wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign wr_bits = wdata_q[CW-1:0];

  always_comb begin
    wr_state_d = wr_state_q;
    unique case (wr_state_q)
      rcr_pkg::RCR_WR_IDLE: begin
        if (wr_commit) begin
          wr_state_d = rcr_pkg::RCR_WR_RESP;
        end
      end
      rcr_pkg::RCR_WR_RESP: begin
        if (b_fire) begin
          wr_state_d = rcr_pkg::RCR_WR_IDLE;
        end
      end
      default: begin
        wr_state_d = rcr_pkg::RCR_WR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      wr_state_q <= rcr_pkg::RCR_WR_IDLE;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      bresp_q <= `RCR_RESP_OKAY;
    end else begin
      wr_state_q <= wr_state_d;
      aw_got_q <= (aw_got_q || aw_fire) && !wr_commit;
      w_got_q <= (w_got_q || w_fire) && !wr_commit;
      if (wr_commit) begin
        bresp_q <= wr_mapped ? `RCR_RESP_OKAY : `RCR_RESP_DECERR;
      end
    end
  end

  // Payload holders carry no reset; they are only read after a transfer.
  always_ff @(posedge clk_sys) begin
    if (aw_fire) begin
      awaddr_q <= s_axi_awaddr;
    end
    if (w_fire) begin
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end
  end

  assign s_axi_bvalid = (wr_state_q == rcr_pkg::RCR_WR_RESP);
  assign s_axi_bresp = bresp_q;

  // ****************************************************************
  // Reset cause flags and regulator control
  // ****************************************************************
  // Software writes load the flags directly, so it may clear or set any
  // of them; the brown-out and power-on flags stay set until software
  // clears them, which it must do to see the next such reset.
  assign ctrl_fl.set = evt_bits;
  assign ctrl_fl.wr_en = wr_commit && wr_sel_ctrl;
  assign ctrl_fl.wr_data = wr_bits & `RCR_CTRL_IMPL_MASK;
  assign ctrl_fl.wr_mask = wr_lanes & `RCR_CTRL_IMPL_MASK;

  // Reset acts as the power-on reset, so the power flags come up set.
  rcr_sticky_bank #(
    .W(CW),
    .RESET_VAL(`RCR_CTRL_RESET),
    .CLEAR_ON_ONE(1'b0)
  ) u_ctrl_bank (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .fl(ctrl_fl)
  );

  assign regulator_standby_keep_on = ctrl_fl.q[`RCR_BIT_KEEP_ON];

  // ****************************************************************
  // Interrupt status, enable and clear
  // ****************************************************************
  // Status is read-only; ones written to the clear register drop bits.
  assign stat_fl.set = evt_bits;
  assign stat_fl.wr_en = wr_commit && wr_sel_clear;
  assign stat_fl.wr_data = wr_bits;
  assign stat_fl.wr_mask = wr_lanes & `RCR_EVENT_MASK;

  rcr_sticky_bank #(
    .W(CW),
    .RESET_VAL('0),
    .CLEAR_ON_ONE(1'b1)
  ) u_status_bank (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .fl(stat_fl)
  );

  assign status = stat_fl.q;
  assign enable_d = ((wr_commit && wr_sel_enable) ?
                     ((wr_lanes & wr_bits) | (~wr_lanes & enable_q)) :
                     enable_q) & `RCR_EVENT_MASK;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      enable_q <= '0;
      irq_q <= 1'b0;
    end else begin
      enable_q <= enable_d;
      irq_q <= |(status & enable_q);
    end
  end

  assign irq = irq_q;

  // ****************************************************************
  // Read channel
  // ****************************************************************
  assign s_axi_arready = (rd_state_q == rcr_pkg::RCR_RD_IDLE);
  assign ar_fire = s_axi_arvalid && s_axi_arready;
  assign r_fire = s_axi_rvalid && s_axi_rready;

  assign rd_word = {s_axi_araddr[`RCR_ADDR_W-1:2], 2'b00};
  assign rd_sel_ctrl = (rd_word == `RCR_OFF_CTRL);
  assign rd_sel_status = (rd_word == `RCR_OFF_IRQ_STATUS);
  assign rd_sel_enable = (rd_word == `RCR_OFF_IRQ_ENABLE);
  assign rd_sel_clear = (rd_word == `RCR_OFF_IRQ_CLEAR);
  assign rd_mapped = rd_sel_ctrl || rd_sel_status || rd_sel_enable ||
                     rd_sel_clear;

  // The clear register is write-only and reads as zero.
  assign rd_field = rd_sel_ctrl ?
                    (ctrl_fl.q & `RCR_CTRL_IMPL_MASK) :
                    rd_sel_status ? status :
                    rd_sel_enable ? enable_q :
                    '0;

  always_comb begin
    rd_state_d = rd_state_q;
    unique case (rd_state_q)
      rcr_pkg::RCR_RD_IDLE: begin
        if (ar_fire) begin
          rd_state_d = rcr_pkg::RCR_RD_RESP;
        end
      end
      rcr_pkg::RCR_RD_RESP: begin
        if (r_fire) begin
          rd_state_d = rcr_pkg::RCR_RD_IDLE;
        end
      end
      default: begin
        rd_state_d = rcr_pkg::RCR_RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rd_state_q <= rcr_pkg::RCR_RD_IDLE;
      rdata_q <= '0;
      rresp_q <= `RCR_RESP_OKAY;
    end else begin
      rd_state_q <= rd_state_d;
      if (ar_fire) begin
        rdata_q <= {{PAD_W{1'b0}}, rd_field};
        rresp_q <= rd_mapped ? `RCR_RESP_OKAY : `RCR_RESP_DECERR;
      end
    end
  end

  assign s_axi_rvalid = (rd_state_q == rcr_pkg::RCR_RD_RESP);
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

endmodule // rcr_top

`default_nettype wire

// >>> tb/rcr_monitor.sv
// Port-level assertions for the reset cause recorder.
`timescale 1ns/100ps
`default_nettype none
`include "rcr_consts.svh"

module rcr_monitor (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [`RCR_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [`RCR_DATA_W-1:0] s_axi_wdata,
  input wire logic [`RCR_STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [`RCR_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [`RCR_DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic evt_config_mismatch,
  input wire logic evt_master_clear_pin,
  input wire logic evt_soft_reset,
  input wire logic evt_watchdog_expiry,
  input wire logic evt_wake_sleep,
  input wire logic evt_wake_idle,
  input wire logic evt_brownout,
  input wire logic evt_power_on,
  input wire logic regulator_standby_keep_on,
  input wire logic irq
);
  wire ar_ctrl = s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == 6'h00;

  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  unused_zero_a:
    assert property (s_axi_rvalid |->
      s_axi_rdata[31:10] == 22'h0 && s_axi_rdata[5] == 1'b0)
    else $error("Unimplemented bit reads one");
  keep_read_a:
    assert property (ar_ctrl |=>
      s_axi_rdata[8] == $past(regulator_standby_keep_on))
    else $error("Standby bit differs from its output");
  keep_write_a:
    assert property ($changed(regulator_standby_keep_on) |->
      $rose(s_axi_bvalid))
    else $error("Standby output moved without a write");
  pin_flag_a:
    assert property ($rose(evt_master_clear_pin) ##2 ar_ctrl |=>
      s_axi_rdata[7])
    else $error("Pin reset flag not set");
  brown_flag_a:
    assert property ($rose(evt_brownout) ##2 ar_ctrl |=> s_axi_rdata[1])
    else $error("Brown-out flag not set");
  rd_answer_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read answer late");
  wr_answer_a:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("Write answer off time");
  rd_decerr_a:
    assert property (s_axi_arvalid && s_axi_arready &&
      s_axi_araddr[7:4] != 4'h0 |=>
      s_axi_rresp == `RCR_RESP_DECERR && s_axi_rdata == 32'h0)
    else $error("Unmapped read answered wrongly");
endmodule // rcr_monitor

bind rcr_top rcr_monitor u_mon (
  .clk_sys(clk_sys), .rstn(rstn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .evt_config_mismatch(evt_config_mismatch),
  .evt_master_clear_pin(evt_master_clear_pin),
  .evt_soft_reset(evt_soft_reset), .evt_watchdog_expiry(evt_watchdog_expiry),
  .evt_wake_sleep(evt_wake_sleep), .evt_wake_idle(evt_wake_idle),
  .evt_brownout(evt_brownout), .evt_power_on(evt_power_on),
  .regulator_standby_keep_on(regulator_standby_keep_on), .irq(irq)
);

`default_nettype wire

// >>> tb/rcr_src_model.sv
// Behavioural model of the reset and power mode event sources.
`timescale 1ns/100ps
`default_nettype none

module rcr_src_model #(
  parameter int HOLD = 1
) (
  input wire logic clk_sys,
  input wire logic [7:0] fire,
  output logic [7:0] evt
);
  // A level held for HOLD cycles still counts as one event.
  int left [8];

  always @(posedge clk_sys) begin
    for (int i = 0; i < 8; i++) begin
      if (fire[i]) begin
        left[i] <= HOLD;
      end else if (left[i] > 0) begin
        left[i] <= left[i] - 1;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      evt[i] = left[i] != 0;
    end
  end
endmodule // rcr_src_model

`default_nettype wire

// >>> tb/reset_cause_recorder_tb_top.sv
// Self-checking testbench of the reset cause recorder.
`timescale 1ns/100ps
`default_nettype none
`include "rcr_consts.svh"

module reset_cause_recorder_tb_top;
  localparam logic [7:0] CTL = `RCR_OFF_CTRL;
  localparam logic [7:0] STA = `RCR_OFF_IRQ_STATUS;
  localparam logic [7:0] ENA = `RCR_OFF_IRQ_ENABLE;
  localparam logic [7:0] CLR = `RCR_OFF_IRQ_CLEAR;
  localparam logic [1:0] OK = `RCR_RESP_OKAY;
  localparam logic [1:0] DE = `RCR_RESP_DECERR;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, fire = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, keep_on, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, want;
  logic [7:0] evt;
  int n_mismatch = 0;
  int compares = 0;
  int bitpos [8] = '{`RCR_BIT_POWER_ON, `RCR_BIT_BROWNOUT, `RCR_BIT_WAKE_IDLE,
    `RCR_BIT_WAKE_SLEEP, `RCR_BIT_WATCHDOG, `RCR_BIT_SOFT_RESET,
    `RCR_BIT_PIN_RESET, `RCR_BIT_CFG_MISMATCH};

  rcr_top u_dut (
    .clk_sys(clk_sys), .rstn(rstn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .evt_power_on(evt[0]), .evt_brownout(evt[1]), .evt_wake_idle(evt[2]),
    .evt_wake_sleep(evt[3]), .evt_watchdog_expiry(evt[4]),
    .evt_soft_reset(evt[5]), .evt_master_clear_pin(evt[6]),
    .evt_config_mismatch(evt[7]), .regulator_standby_keep_on(keep_on),
    .irq(irq)
  );

  rcr_src_model u_src (.clk_sys(clk_sys), .fire(fire), .evt(evt));

  initial begin
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Handshakes are judged 1 ns after an edge; only the next edge moves them.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic aw_t, w_t, b_t;
    logic [1:0] r;
    int n;
    n = 0;
    b_t = 1'b0;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_t && n < 50) begin
      #1;
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      b_t = bvalid;
      r = bresp;
      @(posedge clk_sys);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      n++;
    end
    bready <= 1'b0;
    if (!b_t) n_mismatch++;
    chk("bresp", {30'h0, er}, {30'h0, r});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    logic ar_t, r_t;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    n = 0;
    r_t = 1'b0;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_t && n < 50) begin
      #1;
      ar_t = arvalid && arready;
      r_t = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk_sys);
      if (ar_t) arvalid <= 1'b0;
      n++;
    end
    rready <= 1'b0;
    if (!r_t) n_mismatch++;
    chk("rdata", e, d);
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask

  task automatic pulse(input int i);
    @(posedge clk_sys);
    fire[i] <= 1'b1;
    @(posedge clk_sys);
    fire[i] <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic settle();
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #100_000;
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(CTL, 32'h0000_0003, OK);
    rd(STA, 32'h0000_0000, OK);
    chk("keep_on", 32'h0, {31'h0, keep_on});
    wr(CTL, 32'h0000_0000, OK);
    rd(CTL, 32'h0000_0000, OK);
    want = 32'h0;
    for (int i = 0; i < 8; i++) begin
      pulse(i);
      want[bitpos[i]] = 1'b1;
      rd(CTL, want, OK);
    end
    wr(CTL, 32'hFFFF_FFFF, OK);
    rd(CTL, 32'h0000_03DF, OK);
    chk("keep_on", 32'h1, {31'h0, keep_on});
    wr(CTL, 32'h0000_0000, OK);
    chk("keep_on", 32'h0, {31'h0, keep_on});
    wr(CLR, 32'h0000_02DF, OK);
    rd(STA, 32'h0000_0000, OK);
    wr(STA, 32'hFFFF_FFFF, OK);
    rd(STA, 32'h0000_0000, OK);
    rd(CLR, 32'h0000_0000, OK);
    wr(ENA, 32'hFFFF_FFFF, OK);
    rd(ENA, 32'h0000_02DF, OK);
    wr(ENA, 32'h0000_0010, OK);
    pulse(1);
    settle();
    chk("irq", 32'h0, {31'h0, irq});
    rd(STA, 32'h0000_0002, OK);
    pulse(4);
    settle();
    chk("irq", 32'h1, {31'h0, irq});
    wr(CLR, 32'h0000_0010, OK);
    settle();
    chk("irq", 32'h0, {31'h0, irq});
    rd(STA, 32'h0000_0002, OK);
    rd(8'h40, 32'h0000_0000, DE);
    wr(8'h40, 32'hFFFF_FFFF, DE);
    rd(CTL, 32'h0000_0012, OK);
    // The event lands on the very edge at which the clearing write commits.
    fork
      pulse(5);
      begin
        @(posedge clk_sys);
        wr(CTL, 32'h0000_0000, OK);
      end
    join
    rd(CTL, 32'h0000_0040, OK);
    // Only the upper lane is written, so the flags in bits 7:0 must survive.
    wstrb <= 4'h2;
    wr(CTL, 32'h0000_0100, OK);
    rd(CTL, 32'h0000_0140, OK);
    chk("keep_on", 32'h1, {31'h0, keep_on});
    report_and_stop();
  end
endmodule // reset_cause_recorder_tb_top

`default_nettype wire
